/* usfbc_pkg.sv */
package usfbc_pkg;

    // Register indices; the byte address on the bus is four times the index.
    localparam logic [5:0] IDX_RX_CONTROL  = 6'h06;
    localparam logic [5:0] IDX_FRAME_CTRL  = 6'h07;
    localparam logic [5:0] IDX_BAUD_LO     = 6'h08;
    localparam logic [5:0] IDX_BAUD_HI     = 6'h09;
    localparam logic [5:0] IDX_AB_WINDOW   = 6'h0A;
    localparam logic [5:0] IDX_DEBUG       = 6'h0B;
    localparam logic [5:0] IDX_IR_EVENT    = 6'h0C;
    localparam logic [5:0] IDX_TX_PULSE    = 6'h0D;
    localparam logic [5:0] IDX_STATUS      = 6'h10;

    // Field positions.
    localparam int FRM_MODE_LSB      = 6;
    localparam int FRM_PARITY_LSB    = 4;
    localparam int FRM_STOP_BIT      = 3;
    localparam int FRM_CHAR_LSB      = 0;
    localparam int FRM_SPI_ORDER_BIT = 2;
    localparam int FRM_SPI_PHASE_BIT = 1;
    localparam int RXC_MULTIPROC_ADDR_ENABLE_BIT      = 0;
    localparam int RXC_RXMODE_LSB    = 1;
    localparam int AB_WINDOW_LSB     = 6;
    localparam int DBG_RUN_BIT       = 0;
    localparam int IRE_DISABLE_BIT   = 0;

    // Reset values.
    localparam logic [7:0]  FRAME_CTRL_RESET = 8'h03;
    localparam logic [7:0]  BYTE_REG_RESET   = 8'h00;
    localparam logic [15:0] BAUD_RESET       = 16'h0000;

    typedef enum logic [1:0] {
        MODE_ASYNC,
        MODE_SYNC,
        MODE_INFRARED,
        MODE_HOST_SPI
    } usfbc_mode_e;

    localparam logic [1:0] PAR_EVEN        = 2'h2;
    localparam logic [1:0] PAR_ODD         = 2'h3;
    localparam logic [2:0] CHAR_NINE_LOW   = 3'h6;
    localparam logic [2:0] CHAR_NINE_HIGH  = 3'h7;
    localparam logic [2:0] CHAR_EIGHT      = 3'h3;
    localparam logic [1:0] RXMODE_LIN_AUTO = 2'h3;

    // Baud sampling and the auto-baud window.
    localparam logic [3:0] SAMPLES_PER_BIT_M1 = 4'hF;
    localparam logic [7:0] SAMPLES_PER_PAIR   = 8'h20;
    localparam logic [7:0] AB_TOL_WDW0        = 8'h06;
    localparam logic [7:0] AB_TOL_WDW1        = 8'h05;
    localparam logic [7:0] AB_TOL_WDW2        = 8'h07;
    localparam logic [7:0] AB_TOL_WDW3        = 8'h08;

    // Infrared transmit pulse coding.
    localparam logic [7:0] TX_PULSE_LENGTH_FRACTIONAL = 8'h00;
    localparam logic [7:0] TX_PULSE_LENGTH_DISABLED   = 8'hFF;
    localparam logic [3:0] IR_PULSE_SAMPLES = 4'h3;

    localparam logic [1:0] AXI_OKAY   = 2'h0;
    localparam logic [1:0] AXI_SLVERR = 2'h2;

endpackage

/* usfbc_baud_prescaler.sv */
`timescale 1ns/1ps
module usfbc_baud_prescaler
    import usfbc_pkg::*;
(
    input  wire logic        i_clock,
    input  wire logic        i_rst_n,
    input  wire logic        i_run,
    input  wire logic        i_reload,
    input  wire logic [15:0] i_divisor,
    output logic             o_sample_tick,
    output logic             o_bit_tick
);
    logic [15:0] count_ff;
    logic [3:0]  sample_ff;

    // A reload restarts both counters at once so the new rate is in force on the next cycle.
    always_ff @(posedge i_clock) begin
        if (!i_rst_n || i_reload) begin
            count_ff      <= i_divisor;
            sample_ff     <= SAMPLES_PER_BIT_M1;
            o_sample_tick <= 1'b0;
            o_bit_tick    <= 1'b0;
        end else if (i_run) begin
            o_sample_tick <= (count_ff == 16'h0000);
            o_bit_tick    <= (count_ff == 16'h0000) && (sample_ff == 4'h0);
            if (count_ff == 16'h0000) begin
                count_ff  <= i_divisor;
                sample_ff <= sample_ff - 4'h1;
            end else begin
                count_ff <= count_ff - 16'h0001;
            end
        end else begin
            o_sample_tick <= 1'b0;
            o_bit_tick    <= 1'b0;
        end
    end
endmodule

/* usfbc_ir_tx_encoder.sv */
`timescale 1ns/1ps
module usfbc_ir_tx_encoder
    import usfbc_pkg::*;
(
    input  wire logic       i_clock,
    input  wire logic       i_rst_n,
    input  wire logic       i_coding_on,
    input  wire logic [7:0] i_pulse_length,
    input  wire logic       i_bit_tick,
    input  wire logic       i_sample_tick,
    input  wire logic       i_tx_bit,
    output logic            o_line
);
    logic [7:0] left_ff;
    logic       pulse_ff;
    logic       fractional;

    assign fractional = (i_pulse_length == TX_PULSE_LENGTH_FRACTIONAL);

    // A zero bit becomes one pulse that starts on the bit boundary; a one bit sends nothing.
    always_ff @(posedge i_clock) begin
        if (!i_rst_n || !i_coding_on) begin
            left_ff  <= 8'h00;
            pulse_ff <= 1'b0;
        end else if (i_bit_tick && !i_tx_bit) begin
            left_ff  <= fractional ? {4'h0, IR_PULSE_SAMPLES} : i_pulse_length;
            pulse_ff <= 1'b1;
        end else if (pulse_ff && (fractional ? i_sample_tick : 1'b1)) begin
            left_ff  <= left_ff - 8'h01;
            pulse_ff <= (left_ff != 8'h01);
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            o_line <= 1'b1;
        end else begin
            o_line <= i_coding_on ? !pulse_ff : i_tx_bit;
        end
    end
endmodule

/* usfbc_config.sv */
// The AXI4-Lite interface to the registers is this design's own decision.
`timescale 1ns/1ps
// Behaviour
// - Multiprocessor enable bit set turns multiprocessor communication mode on, clear turns it off.
// - Two-bit mode field picks asynchronous, synchronous, infrared or host SPI operation.
// - Mode value 3 switches frame control to SPI layout: only order and phase bits.
// - Parity field: 0 none, 2 even, 3 odd; 1 is reserved.
// - Transmitter appends one stop bit when stop bit is 0, two when 1.
// - Receiver ignores stop bit count; its frame check is always the same.
// - One character width field serves both directions: 5 to 8, or 9 bits with order.
// - Normal frame control resets to 0x03: asynchronous, no parity, one stop, 8 bits.
// - SPI order bit: 0 sends MSB first, 1 LSB first, both directions alike.
// - SPI phase bit: 0 samples on leading edge, 1 on trailing edge.
// - Sixteen-bit baud divisor is two byte registers, low at base, high at base+1.
// - Any baud divisor write reloads the prescaler at once.
// - Auto-baud window field sets accepted pair count 32 plus or minus 6, 5, 7, 8.
// - Receiver takes 16 samples per bit, so a bit pair spans 32 samples.
// - Debug run clear halts the block and ignores events while CPU is halted.
// - Infrared event enable bit gates event input; writing 1 disables it.
// - Pulse length acts in infrared mode: 0 gives 3/16, 1-254 clocks, 255 off.
module usfbc_config
    import usfbc_pkg::*;
(
    input  wire logic        i_clock,
    input  wire logic        i_rst_n,
    input  wire logic [7:0]  i_awaddr,
    input  wire logic        i_awvalid,
    output logic             o_awready,
    input  wire logic [31:0] i_wdata,
    input  wire logic [3:0]  i_wstrb,
    input  wire logic        i_wvalid,
    output logic             o_wready,
    output logic [1:0]       o_bresp,
    output logic             o_bvalid,
    input  wire logic        i_bready,
    input  wire logic [7:0]  i_araddr,
    input  wire logic        i_arvalid,
    output logic             o_arready,
    output logic [31:0]      o_rdata,
    output logic [1:0]       o_rresp,
    output logic             o_rvalid,
    input  wire logic        i_rready,
    input  wire logic        i_debug_halted,
    input  wire logic        i_ir_event,
    input  wire logic        i_tx_serial,
    input  wire logic [7:0]  i_ab_pair_samples,
    output logic [1:0]       o_comm_mode_select,
    output logic             o_infrared_mode,
    output logic             o_host_spi_mode,
    output logic             o_multiproc_addr_enable,
    output logic             o_parity_enable,
    output logic             o_parity_odd,
    output logic [1:0]       o_tx_stop_bits,
    output logic [3:0]       o_data_bits,
    output logic             o_nine_bit_high_first,
    output logic [3:0]       o_tx_frame_bits,
    output logic [3:0]       o_rx_frame_bits,
    output logic             o_spi_bit_order,
    output logic             o_spi_sample_phase,
    output logic             o_lin_constrained_autobaud,
    output logic             o_ab_in_window,
    output logic             o_run_enable,
    output logic             o_ir_event_accept,
    output logic             o_sample_tick,
    output logic             o_bit_tick,
    output logic             o_tx_line
);
    logic [7:0]  frame_ctrl_ff;
    logic [7:0]  rx_ctrl_ff;
    logic [15:0] baud_ff;
    logic [7:0]  ab_window_ff;
    logic [7:0]  debug_ff;
    logic [7:0]  ir_event_ff;
    logic [7:0]  tx_pulse_ff;

    logic [7:0]  awaddr_ff;
    logic [7:0]  wdata_ff;
    logic        wlane_ff;
    logic        awready_ff;
    logic        wready_ff;
    logic        bvalid_ff;
    logic [1:0]  bresp_ff;
    logic        arready_ff;
    logic        rvalid_ff;
    logic [31:0] rdata_ff;
    logic [1:0]  rresp_ff;

    logic        wr_fire;
    logic [5:0]  wr_idx;
    logic        wr_byte;
    logic        wr_mapped;
    logic [5:0]  rd_idx;
    logic [7:0]  rd_byte;
    logic        rd_mapped;
    logic        baud_reload;
    logic        run_now;
    logic        spi_layout;
    logic [1:0]  nxt_mode;
    logic [7:0]  nxt_frame_ctrl;
    logic [15:0] nxt_baud;
    logic [2:0]  char_code;
    logic [7:0]  ab_tolerance;
    logic [3:0]  data_bits;
    logic        parity_on;
    logic        coding_on;

    // Write channel: address and data are captured independently, in either order.
    assign wr_fire   = !awready_ff && !wready_ff && !bvalid_ff;
    assign wr_idx    = awaddr_ff[7:2];
    assign wr_byte   = wr_fire && wlane_ff;

    // The writable registers sit at consecutive indices, so one range check decodes them.
    assign wr_mapped = (wr_idx >= IDX_RX_CONTROL) && (wr_idx <= IDX_TX_PULSE);

    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            awready_ff <= 1'b1;
            awaddr_ff  <= 8'h00;
        end else if (awready_ff && i_awvalid) begin
            awready_ff <= 1'b0;
            awaddr_ff  <= i_awaddr;
        end else if (bvalid_ff && i_bready) begin
            awready_ff <= 1'b1;
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            wready_ff <= 1'b1;
            wdata_ff  <= 8'h00;
            wlane_ff  <= 1'b0;
        end else if (wready_ff && i_wvalid) begin
            wready_ff <= 1'b0;
            wdata_ff  <= i_wdata[7:0];
            wlane_ff  <= i_wstrb[0];
        end else if (bvalid_ff && i_bready) begin
            wready_ff <= 1'b1;
        end
    end

    // Writes to the status register or an unmapped index complete with an error and change nothing.
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            bvalid_ff <= 1'b0;
            bresp_ff  <= AXI_OKAY;
        end else if (wr_fire) begin
            bvalid_ff <= 1'b1;
            bresp_ff  <= wr_mapped ? AXI_OKAY : AXI_SLVERR;
        end else if (bvalid_ff && i_bready) begin
            bvalid_ff <= 1'b0;
        end
    end

    // A write that selects mode 3 takes only the mode, order and phase bits; the rest keep their value.
    assign nxt_mode       = wdata_ff[FRM_MODE_LSB +: 2];
    assign spi_layout     = (frame_ctrl_ff[FRM_MODE_LSB +: 2] == MODE_HOST_SPI);
    always_comb begin
        nxt_frame_ctrl = wdata_ff;
        if (nxt_mode == MODE_HOST_SPI) begin
            nxt_frame_ctrl = frame_ctrl_ff;
            nxt_frame_ctrl[FRM_MODE_LSB +: 2]  = nxt_mode;
            nxt_frame_ctrl[FRM_SPI_ORDER_BIT]  = wdata_ff[FRM_SPI_ORDER_BIT];
            nxt_frame_ctrl[FRM_SPI_PHASE_BIT]  = wdata_ff[FRM_SPI_PHASE_BIT];
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            frame_ctrl_ff <= FRAME_CTRL_RESET;
        end else if (wr_byte && wr_idx == IDX_FRAME_CTRL) begin
            frame_ctrl_ff <= nxt_frame_ctrl;
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            rx_ctrl_ff <= BYTE_REG_RESET;
        end else if (wr_byte && wr_idx == IDX_RX_CONTROL) begin
            rx_ctrl_ff <= wdata_ff;
        end
    end

    // The prescaler reloads from the next value, so the written divisor counts from the reload on.
    assign nxt_baud = (wr_byte && wr_idx == IDX_BAUD_LO) ? {baud_ff[15:8], wdata_ff}
                    : (wr_byte && wr_idx == IDX_BAUD_HI) ? {wdata_ff, baud_ff[7:0]} : baud_ff;
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            baud_ff <= BAUD_RESET;
        end else begin
            baud_ff <= nxt_baud;
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            ab_window_ff <= BYTE_REG_RESET;
            debug_ff     <= BYTE_REG_RESET;
            ir_event_ff  <= BYTE_REG_RESET;
            tx_pulse_ff  <= BYTE_REG_RESET;
        end else if (wr_byte) begin
            if (wr_idx == IDX_AB_WINDOW) begin
                ab_window_ff <= wdata_ff;
            end
            if (wr_idx == IDX_DEBUG) begin
                debug_ff <= wdata_ff;
            end
            if (wr_idx == IDX_IR_EVENT) begin
                ir_event_ff <= wdata_ff;
            end
            if (wr_idx == IDX_TX_PULSE) begin
                tx_pulse_ff <= wdata_ff;
            end
        end
    end

    // Read channel: one cycle from the address handshake to read data.
    assign rd_idx = i_araddr[7:2];
    always_comb begin
        rd_mapped = 1'b1;
        rd_byte   = 8'h00;
        case (rd_idx)
            IDX_RX_CONTROL: begin
                rd_byte = rx_ctrl_ff;
            end
            IDX_FRAME_CTRL: begin
                rd_byte = frame_ctrl_ff;
                if (spi_layout) begin
                    rd_byte = {frame_ctrl_ff[FRM_MODE_LSB +: 2], 3'h0,
                               frame_ctrl_ff[FRM_SPI_ORDER_BIT], frame_ctrl_ff[FRM_SPI_PHASE_BIT], 1'b0};
                end
            end
            IDX_BAUD_LO: begin
                rd_byte = baud_ff[7:0];
            end
            IDX_BAUD_HI: begin
                rd_byte = baud_ff[15:8];
            end
            IDX_AB_WINDOW: begin
                rd_byte = ab_window_ff;
            end
            IDX_DEBUG: begin
                rd_byte = debug_ff;
            end
            IDX_IR_EVENT: begin
                rd_byte = ir_event_ff;
            end
            IDX_TX_PULSE: begin
                rd_byte = tx_pulse_ff;
            end
            IDX_STATUS: begin
                rd_byte = {4'h0, o_tx_line, o_ab_in_window, o_ir_event_accept, o_run_enable};
            end
            default: begin
                rd_mapped = 1'b0;
            end
        endcase
    end

    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            arready_ff <= 1'b1;
            rvalid_ff  <= 1'b0;
            rdata_ff   <= 32'h0000_0000;
            rresp_ff   <= AXI_OKAY;
        end else if (arready_ff && i_arvalid) begin
            arready_ff <= 1'b0;
            rvalid_ff  <= 1'b1;
            rdata_ff   <= {24'h00_0000, rd_byte};
            rresp_ff   <= rd_mapped ? AXI_OKAY : AXI_SLVERR;
        end else if (rvalid_ff && i_rready) begin
            arready_ff <= 1'b1;
            rvalid_ff  <= 1'b0;
        end
    end

    assign o_awready = awready_ff;
    assign o_wready  = wready_ff;
    assign o_bvalid  = bvalid_ff;
    assign o_bresp   = bresp_ff;
    assign o_arready = arready_ff;
    assign o_rvalid  = rvalid_ff;
    assign o_rdata   = rdata_ff;
    assign o_rresp   = rresp_ff;

    // The block only freezes while the CPU is halted and running in debug is not allowed.
    assign run_now     = debug_ff[DBG_RUN_BIT] || !i_debug_halted;
    assign baud_reload = wr_byte && (wr_idx == IDX_BAUD_LO || wr_idx == IDX_BAUD_HI);

    usfbc_baud_prescaler u_prescaler (
        .i_clock       (i_clock),
        .i_rst_n       (i_rst_n),
        .i_run         (run_now),
        .i_reload      (baud_reload),
        .i_divisor     (nxt_baud),
        .o_sample_tick (o_sample_tick),
        .o_bit_tick    (o_bit_tick)
    );

    // Pulse coding is bypassed outside infrared mode or when the length is all ones.
    assign coding_on = run_now && (frame_ctrl_ff[FRM_MODE_LSB +: 2] == MODE_INFRARED)
                       && (tx_pulse_ff != TX_PULSE_LENGTH_DISABLED);

    usfbc_ir_tx_encoder u_ir_encoder (
        .i_clock        (i_clock),
        .i_rst_n        (i_rst_n),
        .i_coding_on    (coding_on),
        .i_pulse_length (tx_pulse_ff),
        .i_bit_tick     (o_bit_tick),
        .i_sample_tick  (o_sample_tick),
        .i_tx_bit       (i_tx_serial),
        .o_line         (o_tx_line)
    );

    // Reserved width codes fall back to eight bits and the reserved parity code means no parity.
    assign char_code = frame_ctrl_ff[FRM_CHAR_LSB +: 3];
    assign data_bits = (char_code >= CHAR_NINE_LOW) ? 4'h9
                     : (char_code <= CHAR_EIGHT) ? 4'h5 + {1'b0, char_code} : 4'h8;

    assign parity_on = (frame_ctrl_ff[FRM_PARITY_LSB +: 2] == PAR_EVEN)
                       || (frame_ctrl_ff[FRM_PARITY_LSB +: 2] == PAR_ODD);

    assign ab_tolerance = (ab_window_ff[AB_WINDOW_LSB +: 2] == 2'h0) ? AB_TOL_WDW0
                        : (ab_window_ff[AB_WINDOW_LSB +: 2] == 2'h1) ? AB_TOL_WDW1
                        : (ab_window_ff[AB_WINDOW_LSB +: 2] == 2'h2) ? AB_TOL_WDW2 : AB_TOL_WDW3;

    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            o_comm_mode_select      <= MODE_ASYNC;
            o_infrared_mode         <= 1'b0;
            o_host_spi_mode         <= 1'b0;
            o_multiproc_addr_enable <= 1'b0;
        end else begin
            o_comm_mode_select      <= frame_ctrl_ff[FRM_MODE_LSB +: 2];
            o_infrared_mode         <= (frame_ctrl_ff[FRM_MODE_LSB +: 2] == MODE_INFRARED);
            o_host_spi_mode         <= spi_layout;
            o_multiproc_addr_enable <= rx_ctrl_ff[RXC_MULTIPROC_ADDR_ENABLE_BIT];
        end
    end

    // The parity fields are shown as zero in host SPI mode; the other frame fields still follow the register.
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            o_parity_enable       <= 1'b0;
            o_parity_odd          <= 1'b0;
            o_tx_stop_bits        <= 2'h1;
            o_data_bits           <= 4'h8;
            o_nine_bit_high_first <= 1'b0;
            o_tx_frame_bits       <= 4'hA;
            o_rx_frame_bits       <= 4'hA;
        end else begin
            o_parity_enable       <= parity_on && !spi_layout;
            o_parity_odd          <= (frame_ctrl_ff[FRM_PARITY_LSB +: 2] == PAR_ODD) && !spi_layout;
            o_tx_stop_bits        <= frame_ctrl_ff[FRM_STOP_BIT] ? 2'h2 : 2'h1;
            o_data_bits           <= data_bits;
            o_nine_bit_high_first <= (frame_ctrl_ff[FRM_CHAR_LSB +: 3] == CHAR_NINE_HIGH);
            o_tx_frame_bits       <= 4'h1 + data_bits + {3'h0, parity_on}
                                     + (frame_ctrl_ff[FRM_STOP_BIT] ? 4'h2 : 4'h1);
            o_rx_frame_bits       <= 4'h2 + data_bits + {3'h0, parity_on};
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            o_spi_bit_order    <= 1'b0;
            o_spi_sample_phase <= 1'b0;
        end else begin
            o_spi_bit_order    <= spi_layout && frame_ctrl_ff[FRM_SPI_ORDER_BIT];
            o_spi_sample_phase <= spi_layout && frame_ctrl_ff[FRM_SPI_PHASE_BIT];
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            o_lin_constrained_autobaud <= 1'b0;
            o_ab_in_window             <= 1'b0;
        end else begin
            o_lin_constrained_autobaud <= (rx_ctrl_ff[RXC_RXMODE_LSB +: 2] == RXMODE_LIN_AUTO);
            o_ab_in_window             <= (rx_ctrl_ff[RXC_RXMODE_LSB +: 2] == RXMODE_LIN_AUTO)
                                          && (i_ab_pair_samples >= SAMPLES_PER_PAIR - ab_tolerance)
                                          && (i_ab_pair_samples <= SAMPLES_PER_PAIR + ab_tolerance);
        end
    end

    // A set enable bit turns the event input off; halted debug drops events as well.
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            o_run_enable      <= 1'b0;
            o_ir_event_accept <= 1'b0;
        end else begin
            o_run_enable      <= run_now;
            o_ir_event_accept <= i_ir_event && !ir_event_ff[IRE_DISABLE_BIT] && run_now;
        end
    end

endmodule

/* usfbc_config_properties.sv */
`timescale 1ns/1ps
module usfbc_checker (
    input wire logic       i_clock,
    input wire logic       i_rst_n,
    input wire logic       i_ir_event,
    input wire logic [1:0] o_comm_mode_select,
    input wire logic       o_host_spi_mode,
    input wire logic       o_parity_enable,
    input wire logic [1:0] o_tx_stop_bits,
    input wire logic [3:0] o_tx_frame_bits,
    input wire logic [3:0] o_rx_frame_bits,
    input wire logic       o_spi_bit_order,
    input wire logic       o_run_enable,
    input wire logic       o_ir_event_accept,
    input wire logic       o_sample_tick,
    input wire logic       o_bit_tick
);
    default clocking @(posedge i_clock); endclocking
    default disable iff (!i_rst_n);
    // Three idle cycles let a registered tick drain before the halt is judged.
    sequence s_halted; !o_run_enable [*3]; endsequence
    property p_mode; o_host_spi_mode == (o_comm_mode_select == 2'h3); endproperty
    a_mode: assert property (p_mode) else $error("spi decode");
    property p_spi_par; o_host_spi_mode |-> !o_parity_enable; endproperty
    a_spi_par: assert property (p_spi_par) else $error("parity in spi");
    property p_order; !o_host_spi_mode |-> !o_spi_bit_order; endproperty
    a_order: assert property (p_order) else $error("order outside spi");
    property p_stop; o_tx_frame_bits == o_rx_frame_bits + {2'h0, o_tx_stop_bits} - 4'h1; endproperty
    a_stop: assert property (p_stop) else $error("stop count");
    property p_tick; o_bit_tick |-> o_sample_tick; endproperty
    a_tick: assert property (p_tick) else $error("lone bit tick");
    property p_gap; o_bit_tick |=> !o_bit_tick; endproperty
    a_gap: assert property (p_gap) else $error("bit ticks adjacent");
    property p_halt; s_halted |-> !o_sample_tick; endproperty
    a_halt: assert property (p_halt) else $error("tick while halted");
    property p_evt; o_ir_event_accept |-> $past(i_ir_event); endproperty
    a_evt: assert property (p_evt) else $error("event without input");
endmodule
bind usfbc_config usfbc_checker u_props (.*);

/* usfbc_remote.sv */
`timescale 1ns/1ps
module usfbc_remote (
    input  wire logic       i_clock,
    input  wire logic       i_rst_n,
    input  wire logic       i_line,
    output logic      [7:0] o_low_len
);
    logic [7:0] run_ff;
    // Only finished low pulses are reported, so a line stuck low never updates.
    always_ff @(posedge i_clock) begin
        run_ff <= (!i_rst_n || i_line) ? 8'h00 : run_ff + 8'h01;
        if (!i_rst_n) o_low_len <= 8'h00;
        else if (i_line && run_ff != 8'h00) o_low_len <= run_ff;
    end
endmodule

/* usfbc_config_tb.sv */
`timescale 1ns/1ps
module usfbc_config_tb;
    import usfbc_pkg::*;
    logic i_clock, i_rst_n, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready, i_debug_halted, i_ir_event;
    logic i_tx_serial, o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_infrared_mode, o_host_spi_mode;
    logic o_multiproc_addr_enable, o_parity_enable, o_parity_odd, o_nine_bit_high_first, o_spi_bit_order;
    logic o_spi_sample_phase, o_lin_constrained_autobaud, o_ab_in_window, o_run_enable, o_ir_event_accept;
    logic o_sample_tick, o_bit_tick, o_tx_line;
    logic [1:0] o_bresp, o_rresp, o_comm_mode_select, o_tx_stop_bits;
    logic [3:0] i_wstrb, o_data_bits, o_tx_frame_bits, o_rx_frame_bits;
    logic [7:0] i_awaddr, i_araddr, i_ab_pair_samples, low_len;
    logic [31:0] i_wdata, o_rdata;
    int fail_count = 0, checked = 0, n;
    usfbc_config dut (.*);
    usfbc_remote far_end (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_line(o_tx_line), .o_low_len(low_len));
    initial begin
        i_clock = 1'b0;
        forever #50 i_clock = ~i_clock;
    end
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        checked++;
        if (s !== e) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic finish_test();
        $display("mismatches %0d checks %0d", fail_count, checked);
        if (fail_count == 0 && checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic wait_tick();
        n = 0;
        do begin
            @(posedge i_clock);
            n++;
        end while (!o_sample_tick && n < 20);
    endtask
    // The leading edge keeps two back-to-back transfers from driving one signal twice in a step.
    task automatic bus(input logic w, input logic [5:0] a, input logic [7:0] d, input logic [1:0] er);
        @(posedge i_clock);
        {i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready} <= {w, w, w, !w, !w};
        {i_awaddr, i_araddr, i_wdata} <= {a, 2'h0, a, 2'h0, 24'h0, d};
        n = 0;
        do begin
            @(posedge i_clock);
            n++;
            if (o_awready) i_awvalid <= 1'b0;
            if (o_wready) i_wvalid <= 1'b0;
            if (o_arready) i_arvalid <= 1'b0;
        end while (!(w ? o_bvalid : o_rvalid) && n < 20);
        {i_bready, i_rready} <= 2'h0;
        if (n == 20) chk("bus wait", 0, n);
        if (n == 20) finish_test();
        chk("resp", er, w ? o_bresp : o_rresp);
        if (!w) chk("rdata", d, o_rdata);
    endtask
    task automatic t_frames();
        logic [1:0] p;
        logic [3:0] b;
        for (int k = 0; k < 8; k++) begin
            if (k == 4 || k == 5) continue;
            p = (k < 2) ? 2'h0 : {1'b1, k[0]};
            b = (k < 4) ? 4'(k + 5) : 4'h9;
            bus(1, IDX_FRAME_CTRL, {2'h0, p, k[0], 3'(k)}, AXI_OKAY);
            bus(0, IDX_FRAME_CTRL, {2'h0, p, k[0], 3'(k)}, AXI_OKAY);
            chk("bits", b, o_data_bits);
            chk("nine", k == 7, o_nine_bit_high_first);
            chk("parity", p, {o_parity_enable, o_parity_odd});
            chk("tx", b + p[1] + k[0] + 2, o_tx_frame_bits);
            chk("rx", b + p[1] + 2, o_rx_frame_bits);
        end
    endtask
    task automatic t_modes();
        for (int m = 0; m < 4; m++) begin
            bus(1, IDX_FRAME_CTRL, {2'(m), 6'h3E}, AXI_OKAY);
            bus(0, IDX_FRAME_CTRL, {2'(m), (m == 3) ? 6'h06 : 6'h3E}, AXI_OKAY);
            chk("mode", {m == 2, m == 3, 2'(m)}, {o_infrared_mode, o_host_spi_mode, o_comm_mode_select});
            chk("spi", {m == 3, m == 3}, {o_spi_bit_order, o_spi_sample_phase});
        end
    endtask
    task automatic t_baud_ir();
        bus(1, IDX_BAUD_HI, 8'h5A, AXI_OKAY);
        bus(0, IDX_BAUD_HI, 8'h5A, AXI_OKAY);
        bus(1, IDX_BAUD_HI, 8'h00, AXI_OKAY);
        bus(1, IDX_BAUD_LO, 8'h04, AXI_OKAY);
        wait_tick();
        chk("reload", 5, n);
        wait_tick();
        chk("gap", 5, n);
        bus(1, IDX_FRAME_CTRL, 8'h83, AXI_OKAY);
        bus(1, IDX_TX_PULSE, 8'h07, AXI_OKAY);
        i_tx_serial <= 1'b0;
        repeat (200) @(posedge i_clock);
        chk("pulse", 7, low_len);
        i_tx_serial <= 1'b1;
    endtask
    task automatic t_halt();
        {i_debug_halted, i_ir_event} <= 2'h3;
        repeat (4) @(posedge i_clock);
        chk("halt", 0, {o_run_enable, o_ir_event_accept});
        bus(1, IDX_DEBUG, 8'h01, AXI_OKAY);
        repeat (2) @(posedge i_clock);
        chk("run", 3, {o_run_enable, o_ir_event_accept});
        bus(1, IDX_IR_EVENT, 8'h01, AXI_OKAY);
        repeat (2) @(posedge i_clock);
        chk("evoff", 2, {o_run_enable, o_ir_event_accept});
        {i_debug_halted, i_ir_event} <= 2'h0;
    endtask
    task automatic t_rx_ab();
        bus(1, IDX_RX_CONTROL, 8'h07, AXI_OKAY);
        for (int s = 0; s < 8; s++) begin
            if (s == 4) bus(1, IDX_AB_WINDOW, 8'hC0, AXI_OKAY);
            i_ab_pair_samples <= 8'h25 + 8'(s % 4);
            repeat (2) @(posedge i_clock);
            chk("ab", {1'b1, s % 4 < 2 || s > 3}, {o_lin_constrained_autobaud, o_ab_in_window});
        end
        chk("multiproc_addr_enable", 1, o_multiproc_addr_enable);
    endtask
    initial begin
        {i_rst_n, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready, i_debug_halted, i_ir_event} = 8'h00;
        {i_awaddr, i_araddr, i_ab_pair_samples, i_wdata} = 56'h0;
        {i_tx_serial, i_wstrb} = 5'h1F;
        repeat (8) @(posedge i_clock);
        i_rst_n <= 1'b1;
        bus(0, IDX_FRAME_CTRL, 8'h03, AXI_OKAY);
        bus(1, 6'h3F, 8'hFF, AXI_SLVERR);
        t_frames();
        t_modes();
        t_baud_ir();
        t_halt();
        t_rx_ab();
        finish_test();
    end
endmodule
